// [pkg/acq_mode_pkg.sv]
// Constants and carrier types for the acquisition mode control bank.
// Assumes byte-wide host I/O with a 16-bit port address and one clock.
package acq_mode_pkg;

    // ==========================================================
    // Register offsets from the board base address
    localparam logic [15:0] OFF_CONV_GATE   = 16'h0404;
    localparam logic [15:0] OFF_BURST_CTL   = 16'h0405;
    localparam logic [15:0] OFF_EXT_MODE    = 16'h0406;
    localparam logic [15:0] OFF_MODE_STATUS = 16'h0407;

    // ==========================================================
    // Control byte decode: only bit 6 carries meaning
    localparam int          CTL_BIT = 6;
    localparam logic [7:0]  CTL_SET = 8'h40;
    localparam logic [7:0]  CTL_CLR = 8'h00;

    // ==========================================================
    // Status byte field positions
    localparam int ST_CLK_SEL   = 0;
    localparam int ST_WAIT      = 1;
    localparam int ST_ARMED     = 4;
    localparam int ST_EXT       = 5;
    localparam int ST_BURST     = 6;
    localparam logic [7:0] ST_ZERO_MASK = 8'h8c;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic        wr_n;
        logic        rd_n;
        logic        tc;
        logic        clk_sw;
        logic        wait_sw;
        logic [15:0] addr;
        logic [7:0]  data;
    } pin_t;

    localparam pin_t PIN_IDLE = '{wr_n: 1'b1, rd_n: 1'b1, tc: 1'b0,
                                  clk_sw: 1'b0, wait_sw: 1'b0,
                                  addr: 16'h0000, data: 8'h00};

    typedef struct packed {
        logic gate;
        logic burst;
        logic ext;
    } ctl_t;

    localparam ctl_t CTL_RESET = '{gate: 1'b0, burst: 1'b0, ext: 1'b0};

endpackage

// [rtl/pin_sync.sv]
// Two-stage synchroniser for a bundle of asynchronous pins.
// Assumes the bundle is stable for several clocks around each sample.
`timescale 1ns/100ps
module pin_sync
    import acq_mode_pkg::*;
#(
    parameter int          W       = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    // ==========================================================
    // Sync stages
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = i_d;
        next_q    = meta;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            meta <= RST_VAL;
            o_q  <= RST_VAL;
        end else begin
            meta <= next_meta;
            o_q  <= next_q;
        end
    end

endmodule // pin_sync

// [rtl/conv_gate.sv]
// Gates the conversion clock sources with the effective inhibit level.
// Assumes pacer and trigger ticks are one-cycle pulses on i_clk_sys.
`timescale 1ns/100ps
module conv_gate
    import acq_mode_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_inhibit,
    input  wire logic i_pacer_tick,
    input  wire logic i_ext_trig_tick,
    output logic      o_conv_start
);

    // ==========================================================
    // Start pulse
    logic next_start;

    always_comb begin
        next_start = (i_pacer_tick | i_ext_trig_tick) & ~i_inhibit; // [R4]
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_conv_start <= 1'b0;
        end else begin
            o_conv_start <= next_start;
        end
    end

    // ==========================================================
    // Checks
    chk_no_start_inhibit: assert property (@(posedge i_clk_sys) // [R4]
        disable iff (i_rst) i_inhibit |=> !o_conv_start)
        else $error("conversion started while inhibited");

endmodule // conv_gate

// [rtl/acq_mode_ctl.sv]
// Extended-mode control bank: gate, burst and mode registers plus status.
// Assumes host I/O strobes, address, data, DMA terminal count and the
// two board switches arrive as asynchronous pins; DMA single-cycle mode
// and the conversion clock ticks come from logic on i_clk_sys.
//
// Contract
// R1: Writing 40h to gate register sets it; 00h clears it.
// R2: Gate writes act only while extended mode is already enabled.
// R3: Gate register clears at reset and cannot be read back.
// R4: While gate is set, all conversion clock sources are ignored; the code ignores them only while extended mode is also set.
// R5: Terminal count at end of single-cycle DMA sets the gate; the code sets it only while extended mode is set.
// R6: Writing 40h to burst register enables burst; 00h disables it.
// R7: Burst can be enabled only while extended mode is already set.
// R8: Burst register clears at reset and cannot be read back.
// R9: Writing 40h enables extended mode, 00h disables it; write only.
// R10: Extended mode clears at reset, board acts as older board.
// R11: Status register is read only, reads 0001 00XX after reset.
// R12: Status bit 0 shows clock switch: 1 MHz gives 0, 10 MHz 1.
// R13: Status bit 1 shows wait-state switch: selected gives 1.
// R14: Status bit 4 is 0 while gate set, 1 while clear.
// R15: Status bit 5 mirrors the extended mode register.
// R16: Status bit 6 mirrors the burst enable register.
// R17: Host sets gate at setup, clears it to acquire, sets it after.
// R18: Status bits 7, 3, 2 read zero; writes decode only bit 6.
`timescale 1ns/100ps
module acq_mode_ctl
    import acq_mode_pkg::*;
#(
    parameter logic [15:0] BASE_ADDR = 16'h0300
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_io_wr_n,
    input  wire logic        i_io_rd_n,
    input  wire logic [15:0] i_io_addr,
    input  wire logic [7:0]  i_io_data,
    output logic      [7:0]  o_io_data,
    output logic             o_io_data_oe_n,
    input  wire logic        i_dma_tc,
    input  wire logic        i_dma_single,
    input  wire logic        i_clk_sel_sw,
    input  wire logic        i_wait_sel_sw,
    input  wire logic        i_pacer_tick,
    input  wire logic        i_ext_trig_tick,
    output logic             o_conv_start,
    output logic             o_conv_inhibit,
    output logic             o_burst_mode,
    output logic             o_extended_mode
);

    // ==========================================================
    // Address decode
    function automatic logic hit(input logic [15:0] addr,
                                 input logic [15:0] off);
        hit = (addr == 16'(BASE_ADDR + off));
    endfunction

    // ==========================================================
    // Pin synchronisation
    pin_t pins_raw;
    pin_t pins;

    always_comb begin
        pins_raw = '{wr_n: i_io_wr_n, rd_n: i_io_rd_n, tc: i_dma_tc,
                     clk_sw: i_clk_sel_sw, wait_sw: i_wait_sel_sw,
                     addr: i_io_addr, data: i_io_data};
    end

    pin_sync #(
        .W       ($bits(pin_t)),
        .RST_VAL (PIN_IDLE)
    ) u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_d       (pins_raw),
        .o_q       (pins)
    );

    // ==========================================================
    // Strobe edges
    logic prev_wr_n;
    logic prev_tc;
    logic next_prev_wr_n;
    logic next_prev_tc;
    logic wr_pulse;
    logic tc_pulse;
    logic wr_bit;

    always_comb begin
        next_prev_wr_n = pins.wr_n;
        next_prev_tc   = pins.tc;
        wr_pulse       = prev_wr_n & ~pins.wr_n;
        tc_pulse       = ~prev_tc & pins.tc;
        wr_bit         = pins.data[CTL_BIT]; // [R18]
    end

    // ==========================================================
    // Control registers
    ctl_t ctl;
    ctl_t next_ctl;
    logic wr_gate;
    logic wr_burst;
    logic wr_ext;
    logic tc_stop;

    always_comb begin
        wr_gate  = wr_pulse & hit(pins.addr, OFF_CONV_GATE);
        wr_burst = wr_pulse & hit(pins.addr, OFF_BURST_CTL);
        wr_ext   = wr_pulse & hit(pins.addr, OFF_EXT_MODE);
        tc_stop  = tc_pulse & i_dma_single & ctl.ext; // [R5]
        next_ctl = ctl;
        if (wr_ext) begin
            next_ctl.ext = wr_bit; // [R9]
        end
        if (wr_gate && ctl.ext) begin
            next_ctl.gate = wr_bit; // [R1] [R2]
        end
        if (tc_stop) begin
            next_ctl.gate = 1'b1; // [R5]
        end
        if (wr_burst && ctl.ext) begin
            next_ctl.burst = wr_bit; // [R6] [R7]
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ctl       <= CTL_RESET; // [R3] [R8] [R10]
            prev_wr_n <= 1'b1;
            prev_tc   <= 1'b0;
        end else begin
            ctl       <= next_ctl;
            prev_wr_n <= next_prev_wr_n;
            prev_tc   <= next_prev_tc;
        end
    end

    // ==========================================================
    // Mode outputs
    logic next_inhibit;
    logic next_burst_mode;
    logic next_ext_mode;

    always_comb begin
        next_inhibit    = next_ctl.gate & next_ctl.ext; // [R2]
        next_burst_mode = next_ctl.burst & next_ctl.ext; // [R7]
        next_ext_mode   = next_ctl.ext;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_conv_inhibit  <= 1'b0;
            o_burst_mode    <= 1'b0;
            o_extended_mode <= 1'b0;
        end else begin
            o_conv_inhibit  <= next_inhibit;
            o_burst_mode    <= next_burst_mode;
            o_extended_mode <= next_ext_mode;
        end
    end

    conv_gate u_conv_gate (
        .i_clk_sys       (i_clk_sys),
        .i_rst           (i_rst),
        .i_inhibit       (o_conv_inhibit),
        .i_pacer_tick    (i_pacer_tick),
        .i_ext_trig_tick (i_ext_trig_tick),
        .o_conv_start    (o_conv_start)
    );

    // ==========================================================
    // Status readback
    logic [7:0] status;
    logic [7:0] next_data;
    logic       next_oe_n;
    logic       rd_status;

    always_comb begin
        status              = 8'h00; // [R18]
        status[ST_CLK_SEL]  = pins.clk_sw; // [R12]
        status[ST_WAIT]     = pins.wait_sw; // [R13]
        status[ST_ARMED]    = ~ctl.gate; // [R14]
        status[ST_EXT]      = ctl.ext; // [R15]
        status[ST_BURST]    = ctl.burst; // [R16]
        rd_status = ~pins.rd_n & hit(pins.addr, OFF_MODE_STATUS); // [R11]
        next_data = rd_status ? status : 8'h00;
        next_oe_n = ~rd_status; // [R3] [R8] [R9]
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_io_data      <= 8'h00;
            o_io_data_oe_n <= 1'b1;
        end else begin
            o_io_data      <= next_data;
            o_io_data_oe_n <= next_oe_n;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    chk_gate_set_write: assert property ( // [R1]
        wr_gate && ctl.ext && wr_bit |=> ctl.gate && o_conv_inhibit)
        else $error("gate not set by 40h write");

    chk_gate_clear_write: assert property ( // [R1]
        wr_gate && ctl.ext && !wr_bit && !tc_stop |=> !ctl.gate)
        else $error("gate not cleared by 00h write");

    chk_gate_needs_ext: assert property ( // [R2]
        !ctl.ext && !wr_ext |=> !o_conv_inhibit && $stable(ctl.gate))
        else $error("gate acted without extended mode");

    chk_tc_stops_conv: assert property ( // [R5]
        tc_stop |=> ctl.gate ##0 o_conv_inhibit ##1 !o_conv_start)
        else $error("terminal count did not stop conversions");

    chk_tc_needs_single: assert property ( // [R5]
        tc_pulse && !i_dma_single && !wr_gate |=> $stable(ctl.gate))
        else $error("gate set outside single-cycle dma");

    chk_burst_write: assert property ( // [R6]
        wr_burst && ctl.ext |=> ctl.burst == $past(wr_bit))
        else $error("burst register missed a write");

    chk_burst_needs_ext: assert property ( // [R7]
        !ctl.ext && !wr_ext |=> !o_burst_mode)
        else $error("burst enabled without extended mode");

    chk_ext_write: assert property ( // [R9]
        wr_ext |=> ctl.ext == $past(wr_bit) ##0 o_extended_mode == ctl.ext)
        else $error("extended mode missed a write");

    chk_reset_clear: assert property ( // [R10]
        $fell(i_rst) |-> ctl == CTL_RESET && !o_conv_inhibit
            && !o_burst_mode && !o_extended_mode && o_io_data_oe_n)
        else $error("control state not cleared by reset");

    chk_status_fields: assert property ( // [R14]
        rd_status |=> !o_io_data_oe_n
            && o_io_data[ST_ARMED] == !$past(ctl.gate)
            && o_io_data[ST_EXT] == $past(ctl.ext)
            && o_io_data[ST_BURST] == $past(ctl.burst)
            && o_io_data[ST_CLK_SEL] == $past(pins.clk_sw)
            && o_io_data[ST_WAIT] == $past(pins.wait_sw)
            && (o_io_data & ST_ZERO_MASK) == 8'h00)
        else $error("status byte wrong");

    chk_write_only: assert property ( // [R3]
        !rd_status |=> o_io_data_oe_n && o_io_data == 8'h00)
        else $error("bus driven outside a status read");

    // ==========================================================
    // Checks on refused and read-only accesses
    chk_gate_refused: assert property ( // [R2]
        wr_gate && !ctl.ext |=> $stable(ctl.gate) && !o_conv_inhibit)
        else $error("gate write taken without extended mode");

    chk_burst_refused: assert property ( // [R7]
        wr_burst && !ctl.ext |=> $stable(ctl.burst) && !o_burst_mode)
        else $error("burst write taken without extended mode");

    chk_status_ro: assert property ( // [R11]
        wr_pulse && hit(pins.addr, OFF_MODE_STATUS) && !tc_stop
            |=> $stable(ctl))
        else $error("write to status register changed state");

    chk_read_keeps_state: assert property ( // [R11]
        rd_status && !wr_pulse && !tc_pulse |=> $stable(ctl))
        else $error("status read changed control state");

    chk_ext_clear_hides: assert property ( // [R15]
        wr_ext && !wr_bit |=> !ctl.ext && !o_extended_mode
            && !o_conv_inhibit && !o_burst_mode)
        else $error("mode outputs left on after extended mode off");

    chk_ext_needs_write: assert property ( // [R10]
        !wr_ext |=> $stable(ctl.ext))
        else $error("extended mode changed without a write");

    chk_oe_addr: assert property ( // [R9]
        !o_io_data_oe_n |-> !$past(i_io_rd_n, 3)
            && $past(i_io_addr, 3) == 16'(BASE_ADDR + OFF_MODE_STATUS))
        else $error("bus driven for an address other than status");

    chk_wr_data_pin: assert property ( // [R18]
        wr_ext |=> ctl.ext == $past(i_io_data[CTL_BIT], 3))
        else $error("extended mode not taken from the control bit");

    chk_gate_write_pin: assert property ( // [R1]
        wr_gate && ctl.ext && !tc_stop
            |=> ctl.gate == $past(i_io_data[CTL_BIT], 3))
        else $error("gate not taken from the control bit");

    // ==========================================================
    // Checks on status pins
    chk_status_clk_pin: assert property ( // [R12]
        rd_status |=> o_io_data[ST_CLK_SEL] == $past(i_clk_sel_sw, 3))
        else $error("clock switch bit does not follow its pin");

    chk_status_wait_pin: assert property ( // [R13]
        rd_status |=> o_io_data[ST_WAIT] == $past(i_wait_sel_sw, 3))
        else $error("wait switch bit does not follow its pin");

    chk_status_after_rst: assert property ( // [R11]
        $fell(i_rst) |-> ##2 status[ST_ARMED] && !status[ST_EXT]
            && !status[ST_BURST] && (status & ST_ZERO_MASK) == 8'h00)
        else $error("status byte wrong after reset");

    // ==========================================================
    // Checks on conversions
    chk_gate_holds: assert property ( // [R5]
        ctl.gate && !wr_gate |=> ctl.gate)
        else $error("gate cleared without a host write");

    chk_tc_needs_ext: assert property ( // [R5]
        tc_pulse && !ctl.ext && !wr_gate |=> $stable(ctl.gate))
        else $error("gate set by terminal count without extended mode");

    chk_conv_allowed: assert property ( // [R4]
        !o_conv_inhibit && (i_pacer_tick || i_ext_trig_tick)
            |=> o_conv_start)
        else $error("tick lost while conversions allowed");

    chk_start_cause: assert property ( // [R4]
        o_conv_start |-> $past(i_pacer_tick || i_ext_trig_tick)
            && !$past(o_conv_inhibit))
        else $error("conversion start without an allowed tick");

    chk_burst_clear: assert property ( // [R6]
        wr_burst && ctl.ext && !wr_bit |=> !ctl.burst && !o_burst_mode)
        else $error("burst left on after 00h write");

    cov_tc_stop: cover property (ctl.ext ##1 tc_stop ##1 ctl.gate);
    cov_rearm: cover property (ctl.gate ##[1:20] wr_gate && !wr_bit);
    cov_burst_on: cover property (wr_burst && ctl.ext && wr_bit);
    cov_status_rd: cover property (rd_status ##1 !o_io_data_oe_n);
    cov_gate_refused: cover property (wr_gate && !ctl.ext);

endmodule // acq_mode_ctl

// [dv/host_bus_model.sv]
// Host bus and DMA controller model for the acquisition mode bank.
// Assumes one clock; the model moves its pins 1 ns after a rising edge.
`timescale 1ns/100ps
module host_bus_model (
    input  wire logic        i_clk_sys,
    input  wire logic [7:0]  i_io_data,
    input  wire logic        i_io_data_oe_n,
    output logic             o_wr_n,
    output logic             o_rd_n,
    output logic [15:0]      o_addr,
    output logic [7:0]       o_data,
    output logic             o_tc
);
    // ==========================================================
    // Idle bus
    initial begin
        o_wr_n = 1'b1;
        o_rd_n = 1'b1;
        o_addr = 16'h0000;
        o_data = 8'h5a;
        o_tc   = 1'b0;
    end

    // ==========================================================
    // Bus cycles
    task automatic step(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    // Strobe held low 4 clocks, then idle 4 clocks
    task automatic io_write(input logic [15:0] a, input logic [7:0] d);
        o_addr = a;
        o_data = d;
        o_wr_n = 1'b0;
        step(4);
        o_wr_n = 1'b1;
        step(1);
        o_data = ~d;
        step(3);
    endtask

    task automatic io_read(input logic [15:0] a, output logic [7:0] d,
                           output logic drove);
        d = 8'h00;
        drove = 1'b0;
        o_addr = a;
        o_rd_n = 1'b0;
        for (int n = 0; n < 8 && !drove; n++) begin
            step(1);
            if (i_io_data_oe_n === 1'b0) begin
                drove = 1'b1;
                d = i_io_data;
            end
        end
        o_rd_n = 1'b1;
        step(6);
    endtask

    // Terminal count at the end of a transfer
    task automatic dma_end();
        o_tc = 1'b1;
        step(4);
        o_tc = 1'b0;
        step(4);
    endtask
endmodule // host_bus_model

// [dv/testbench.sv]
// Self-checking bench for the acquisition mode control bank.
// Assumes the host bus model drives all host pins and terminal count.
`timescale 1ns/100ps
module testbench;
    import acq_mode_pkg::*;
    localparam logic [15:0] BASE = 16'h0300;
    logic        clk, rst, wr_n, rd_n, tc, single, clk_sw, wait_sw;
    logic        pacer, trig, oe_n, conv_start, inhibit, burst, ext_mode;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata, d;
    logic        dv;
    int          err_total, checked, cycles;

    acq_mode_ctl #(.BASE_ADDR(BASE)) i_dut (
        .i_clk_sys(clk), .i_rst(rst), .i_io_wr_n(wr_n), .i_io_rd_n(rd_n),
        .i_io_addr(addr), .i_io_data(wdata), .o_io_data(rdata),
        .o_io_data_oe_n(oe_n), .i_dma_tc(tc), .i_dma_single(single),
        .i_clk_sel_sw(clk_sw), .i_wait_sel_sw(wait_sw),
        .i_pacer_tick(pacer), .i_ext_trig_tick(trig),
        .o_conv_start(conv_start), .o_conv_inhibit(inhibit),
        .o_burst_mode(burst), .o_extended_mode(ext_mode));

    host_bus_model i_host (
        .i_clk_sys(clk), .i_io_data(rdata), .i_io_data_oe_n(oe_n),
        .o_wr_n(wr_n), .o_rd_n(rd_n), .o_addr(addr), .o_data(wdata),
        .o_tc(tc));

    // ==========================================================
    // Clock and hang limit
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            report_and_stop();
        end
    end

    // ==========================================================
    // Helpers
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] st(input logic g, input logic b,
                                      input logic e);
        return {1'b0, b, e, ~g, 2'b00, wait_sw, clk_sw};
    endfunction

    task automatic rd_st(input logic [7:0] exp);
        i_host.io_read(BASE + OFF_MODE_STATUS, d, dv);
        check({7'h00, dv}, 8'h01);
        check(d, exp);
    endtask

    task automatic wr(input logic [15:0] off, input logic [7:0] v);
        i_host.io_write(BASE + off, v);
    endtask

    task automatic outs(input logic [2:0] exp);
        check({5'h00, inhibit, burst, ext_mode}, {5'h00, exp});
    endtask

    // One tick on pacer or external clock; start expected next edge
    task automatic tick(input logic via_trig, input logic exp);
        pacer = !via_trig;
        trig = via_trig;
        i_host.step(1);
        pacer = 1'b0;
        trig = 1'b0;
        check({7'h00, conv_start}, {7'h00, exp});
        i_host.step(1);
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        i_host.step(3);
    endtask

    task automatic report_and_stop();
        $display("Counts: checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Test sequence
    initial begin
        rst = 1'b1;
        single = 1'b1;
        clk_sw = 1'b0;
        wait_sw = 1'b1;
        pacer = 1'b0;
        trig = 1'b0;
        do_reset();
        rd_st(st(0, 0, 0));
        outs(3'b000);
        for (int k = 0; k < 4; k++) begin
            {wait_sw, clk_sw} = 2'(k);
            i_host.step(4);
            rd_st(st(0, 0, 0));
        end
        $display("test reset and switches done");

        wr(OFF_CONV_GATE, CTL_SET);
        wr(OFF_BURST_CTL, CTL_SET);
        i_host.dma_end();
        rd_st(st(0, 0, 0));
        tick(1'b0, 1'b1);
        for (int k = 0; k < 3; k++) begin
            i_host.io_read(BASE + OFF_CONV_GATE + 16'(k), d, dv);
            check({7'h00, dv}, 8'h00);
        end
        $display("test refusals done");

        wr(OFF_EXT_MODE, CTL_SET);
        outs(3'b001);
        rd_st(st(0, 0, 1));
        wr(OFF_CONV_GATE, CTL_SET);
        outs(3'b101);
        rd_st(st(1, 0, 1));
        tick(1'b0, 1'b0);
        tick(1'b1, 1'b0);
        wr(OFF_CONV_GATE, 8'hbf);
        outs(3'b001);
        tick(1'b0, 1'b1);
        tick(1'b1, 1'b1);
        rd_st(st(0, 0, 1));
        $display("test gate done");

        wr(OFF_BURST_CTL, CTL_SET);
        outs(3'b011);
        rd_st(st(0, 1, 1));
        wr(OFF_BURST_CTL, CTL_CLR);
        outs(3'b001);
        rd_st(st(0, 0, 1));
        wr(OFF_MODE_STATUS, 8'hff);
        outs(3'b001);
        rd_st(st(0, 0, 1));
        $display("test burst done");

        single = 1'b0;
        i_host.dma_end();
        outs(3'b001);
        single = 1'b1;
        i_host.dma_end();
        outs(3'b101);
        rd_st(st(1, 0, 1));
        tick(1'b1, 1'b0);
        wr(OFF_CONV_GATE, CTL_CLR);
        outs(3'b001);
        $display("test terminal count done");

        wr(OFF_BURST_CTL, CTL_SET);
        wr(OFF_EXT_MODE, CTL_CLR);
        outs(3'b000);
        rd_st(st(0, 1, 0));
        do_reset();
        rd_st(st(0, 0, 0));
        outs(3'b000);
        $display("test mode off and reset done");
        report_and_stop();
    end
endmodule // testbench
